// File: verilog/latchoff_defs.svh
// timing constants for the latch-off supervisor
`ifndef LATCHOFF_DEFS_SVH
`define LATCHOFF_DEFS_SVH

`define CLK_PERIOD_PS        5000
`define HIGH_BLANK_TIME_NS   50000
`define LOW_BLANK_TIME_NS    350000
`define HIGH_BLANK_CYCLES    ((`HIGH_BLANK_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define LOW_BLANK_CYCLES     ((`LOW_BLANK_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define SOFT_START_TIME_NS   4000000
// divide first: the time in picoseconds would overflow a 32-bit int
`define SOFT_START_CYCLES    (`SOFT_START_TIME_NS / (`CLK_PERIOD_PS / 1000))
`define BLANK_CNT_WIDTH      20

`endif

// File: verilog/latchoff_pkg.sv
// types for the latch-off supervisor
package latchoff_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_START,
    ST_SOFT_START,
    ST_RUN,
    ST_LATCHED,
    ST_THERMAL
  } sup_state_t;
endpackage : latchoff_pkg

// File: verilog/trip_if.sv
// trip request and qualified result between supervisor and its filters
`timescale 1ns/1ps
interface trip_if;
  logic raw;
  logic enable;
  logic qualified;
  modport filt (input raw, input enable, output qualified);
  modport ctrl (output raw, output enable, input qualified);
endinterface : trip_if

// File: verilog/trip_blanker.sv
// blanking filter: passes a trip only after it persists past a count
`timescale 1ns/1ps
module trip_blanker #(
  parameter int WIDTH = 20
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] blank_cycles,
  trip_if.filt                  trip
);
  logic [WIDTH-1:0] count_reg;
  logic             qual_reg;

  // any gap in the trip restarts the count, so short spikes never qualify
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_reg <= '0;
    end else if (!trip.raw || !trip.enable) begin
      count_reg <= '0;
    end else if (count_reg <= blank_cycles) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      qual_reg <= 1'b0;
    end else begin
      qual_reg <= trip.raw && trip.enable && (count_reg >= blank_cycles);
    end
  end

  assign trip.qualified = qual_reg;
endmodule : trip_blanker

// File: verilog/latchoff_thermal_fault_supervisor.sv
// latch-off window, start-up gating, thermistor bias boost and thermal shutdown
`timescale 1ns/1ps
`include "latchoff_defs.svh"

// How it works
// - run only inside window; trips latch off
// - high trips shorter than 50 us ignored
// - low trips shorter than 350 us ignored
// - latch cleared by brown-out or supply reset
// - comparators ignored before supply start threshold
// - high trip checked at start threshold
// - low trip honoured after soft-start only
// - thermistor bias doubled during soft-start
// - thermal shutdown stops drive, disables source
// - thermal shutdown resets internal control state
// - thermal clear re-enables source and restarts
module latchoff_thermal_fault_supervisor
  import latchoff_pkg::*;
#(
  parameter int                 CNT_WIDTH   = `BLANK_CNT_WIDTH,
  parameter logic [CNT_WIDTH-1:0] HIGH_BLANK = CNT_WIDTH'(`HIGH_BLANK_CYCLES),
  parameter logic [CNT_WIDTH-1:0] LOW_BLANK  = CNT_WIDTH'(`LOW_BLANK_CYCLES),
  parameter int                 SS_WIDTH    = 20,
  parameter logic [SS_WIDTH-1:0]  SOFT_START = SS_WIDTH'(`SOFT_START_CYCLES)
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic supply_start_threshold,
  input  wire logic supply_reset_level,
  input  wire logic brown_out,
  input  wire logic high_latch_trip,
  input  wire logic low_latch_trip,
  input  wire logic over_temperature,
  input  wire logic pwm_demand,
  output logic      gate_drive_output,
  output logic      boosted_thermistor_current,
  output logic      high_voltage_source_enable,
  output logic      latched_off,
  output logic      soft_start_active
);

  sup_state_t          state_reg;
  sup_state_t          state_next;
  logic [SS_WIDTH-1:0] ss_count_reg;
  logic                drive_reg;
  logic                boost_reg;
  logic                hv_en_reg;
  logic                latch_reg;
  logic                ss_reg;
  logic                clear_event;
  logic                ss_done;

  trip_if high_trip ();
  trip_if low_trip ();

  // comparators are blind until the supply reaches its start threshold
  assign high_trip.raw    = high_latch_trip;
  assign high_trip.enable = (state_reg == ST_SOFT_START) || (state_reg == ST_RUN)
                            || (state_reg == ST_WAIT_START && supply_start_threshold);
  assign low_trip.raw     = low_latch_trip;
  assign low_trip.enable  = (state_reg == ST_RUN);

  trip_blanker #(
    .WIDTH        (CNT_WIDTH)
  ) u_high_blank (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .blank_cycles (HIGH_BLANK),
    .trip         (high_trip)
  );

  trip_blanker #(
    .WIDTH        (CNT_WIDTH)
  ) u_low_blank (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .blank_cycles (LOW_BLANK),
    .trip         (low_trip)
  );

  assign clear_event = brown_out || supply_reset_level;
  assign ss_done     = (ss_count_reg >= SOFT_START - 1'b1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (!clear_event) begin
          state_next = ST_WAIT_START;
        end
      end
      ST_WAIT_START: begin
        // high trip state must settle before switching is allowed
        if (supply_start_threshold && !high_latch_trip) begin
          state_next = ST_SOFT_START;
        end
      end
      ST_SOFT_START: begin
        if (high_trip.qualified) begin
          state_next = ST_LATCHED;
        end else if (ss_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (high_trip.qualified || low_trip.qualified) begin
          state_next = ST_LATCHED;
        end
      end
      ST_LATCHED: begin
        if (clear_event) begin
          state_next = ST_OFF;
        end
      end
      ST_THERMAL: begin
        if (!over_temperature) begin
          state_next = ST_OFF;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    // a qualified high trip while waiting also latches
    if (state_reg == ST_WAIT_START && high_trip.qualified) begin
      state_next = ST_LATCHED;
    end
    // a clearing event restarts everything except an active thermal fault
    if (clear_event && state_reg != ST_THERMAL) begin
      state_next = ST_OFF;
    end
    if (over_temperature) begin
      state_next = ST_THERMAL;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ss_count_reg <= '0;
    end else if (state_reg == ST_SOFT_START && !ss_done) begin
      ss_count_reg <= ss_count_reg + 1'b1;
    end else if (state_reg != ST_SOFT_START) begin
      ss_count_reg <= '0;
    end
  end

  // drive follows demand only in soft-start and run; thermal fault kills it at once
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      drive_reg <= 1'b0;
    end else if (over_temperature) begin
      drive_reg <= 1'b0;
    end else if (state_next == ST_SOFT_START || state_next == ST_RUN) begin
      drive_reg <= pwm_demand;
    end else begin
      drive_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      boost_reg <= 1'b0;
      ss_reg    <= 1'b0;
    end else begin
      boost_reg <= (state_next == ST_SOFT_START);
      ss_reg    <= (state_next == ST_SOFT_START);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hv_en_reg <= 1'b1;
    end else begin
      hv_en_reg <= !over_temperature && (state_next != ST_THERMAL);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      latch_reg <= 1'b0;
    end else begin
      latch_reg <= (state_next == ST_LATCHED);
    end
  end

  assign gate_drive_output          = drive_reg;
  assign boosted_thermistor_current = boost_reg;
  assign high_voltage_source_enable = hv_en_reg;
  assign latched_off                = latch_reg;
  assign soft_start_active          = ss_reg;

endmodule : latchoff_thermal_fault_supervisor

// File: sim/supervisor_sva.sv
// assertions on the latch-off supervisor ports
`timescale 1ns/1ps
module supervisor_sva #(
  parameter int HIGH_BLANK = 8,
  parameter int LOW_BLANK  = 20
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic supply_start_threshold,
  input wire logic supply_reset_level,
  input wire logic brown_out,
  input wire logic high_latch_trip,
  input wire logic low_latch_trip,
  input wire logic over_temperature,
  input wire logic pwm_demand,
  input wire logic gate_drive_output,
  input wire logic boosted_thermistor_current,
  input wire logic high_voltage_source_enable,
  input wire logic latched_off,
  input wire logic soft_start_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  int hi_run;
  int lo_run;
  // consecutive trip lengths, the only cause a latch may have
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hi_run <= 0;
      lo_run <= 0;
    end else begin
      hi_run <= high_latch_trip ? hi_run + 1 : 0;
      lo_run <= low_latch_trip ? lo_run + 1 : 0;
    end
  end
  sequence shut_s;
    !gate_drive_output && !high_voltage_source_enable;
  endsequence
  drive_window_a: assert property (
    gate_drive_output |-> $past(pwm_demand) && !latched_off) else $error("drive outside window");
  latch_drive_a: assert property (latched_off |-> !gate_drive_output)
    else $error("drive while latched");
  trip_blank_a: assert property ($rose(latched_off) |->
    $past(hi_run) >= HIGH_BLANK || $past(lo_run) >= LOW_BLANK) else $error("short trip latched");
  latch_hold_a: assert property (
    latched_off && !brown_out && !supply_reset_level && !over_temperature |=> latched_off)
    else $error("latch lost");
  latch_clear_a: assert property (
    latched_off && (brown_out || supply_reset_level) |=> !latched_off) else $error("no clear");
  start_gate_a: assert property ($rose(soft_start_active) |->
    $past(supply_start_threshold) && !$past(high_latch_trip)) else $error("bad start");
  boost_ss_a: assert property (boosted_thermistor_current == soft_start_active)
    else $error("boost mismatch");
  thermal_stop_a: assert property (over_temperature |=> shut_s)
    else $error("thermal not stopped");
  thermal_reset_a: assert property (over_temperature |=> !latched_off && !soft_start_active)
    else $error("state kept in thermal");
  thermal_clear_a: assert property ($fell(over_temperature) |-> ##[1:3] high_voltage_source_enable)
    else $error("source not back");
endmodule : supervisor_sva
bind latchoff_thermal_fault_supervisor supervisor_sva #(
  .HIGH_BLANK(HIGH_BLANK), .LOW_BLANK(LOW_BLANK)) chk_u (.*);

// File: sim/latch_pin_model.sv
// thermistor and fault network seen through the window comparators
`timescale 1ns/1ps
module latch_pin_model (
  input  wire logic sys_clk,
  input  wire logic hot,
  input  wire logic fault,
  output logic      high_latch_trip = 1'h0,
  output logic      low_latch_trip = 1'h0
);
  // pin capacitor delays each comparator by one clock
  always @(posedge sys_clk) begin
    high_latch_trip <= fault;
    low_latch_trip  <= hot;
  end
endmodule : latch_pin_model

// File: sim/latchoff_thermal_fault_supervisor_test.sv
// testbench for the latch-off supervisor
`timescale 1ns/1ps
module latchoff_thermal_fault_supervisor_test;
  logic sys_clk, reset, supply_start_threshold, supply_reset_level, brown_out;
  logic over_temperature, pwm_demand, hot, fault, high_latch_trip, low_latch_trip;
  logic gate_drive_output, boosted_thermistor_current, high_voltage_source_enable;
  logic latched_off, soft_start_active;
  int   n_errors, n_checks, cycles;
  // short counts keep the run brief
  latchoff_thermal_fault_supervisor #(.HIGH_BLANK(8), .LOW_BLANK(20), .SOFT_START(50)) dut_u (.*);
  latch_pin_model net_u (.*);
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t output differs", $time);
    end
  endtask : chk
  task give_verdict;
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task trip(input bit lo, input int n);
    tick(1);
    if (lo) hot <= 1'h1;
    else fault <= 1'h1;
    tick(n);
    hot <= 1'h0;
    fault <= 1'h0;
  endtask : trip
  task clr(input bit lvl);
    tick(1);
    if (lvl) supply_reset_level <= 1'h1;
    else brown_out <= 1'h1;
    tick(1);
    supply_reset_level <= 1'h0;
    brown_out <= 1'h0;
    tick(3);
    #1;
    chk(latched_off, 1'h0);
    chk(soft_start_active, 1'h1);
  endtask : clr
  task t_pre;
    tick(1);
    fault <= 1'h1;
    tick(20);
    #1;
    chk(latched_off, 1'h0);
    tick(1);
    supply_start_threshold <= 1'h1;
    tick(3);
    #1;
    chk(soft_start_active, 1'h0);
    tick(12);
    #1;
    chk(latched_off, 1'h1);
    tick(1);
    fault <= 1'h0;
    clr(1'h1);
  endtask : t_pre
  task t_run;
    tick(1);
    pwm_demand <= 1'h1;
    hot <= 1'h1;
    tick(2);
    #1;
    chk(boosted_thermistor_current, 1'h1);
    chk(gate_drive_output, 1'h1);
    tick(28);
    hot <= 1'h0;
    tick(30);
    #1;
    chk(latched_off, 1'h0);
    chk(boosted_thermistor_current, 1'h0);
  endtask : t_run
  task t_window(input bit lo, input int blank);
    trip(lo, blank);
    tick(6);
    #1;
    chk(latched_off, 1'h0);
    trip(lo, blank + 4);
    tick(4);
    #1;
    chk(latched_off, 1'h1);
    chk(gate_drive_output, 1'h0);
    clr(1'h0);
    tick(55);
  endtask : t_window
  task t_therm;
    tick(1);
    over_temperature <= 1'h1;
    tick(1);
    #1;
    chk(gate_drive_output | high_voltage_source_enable, 1'h0);
    chk(soft_start_active | latched_off, 1'h0);
    tick(1);
    over_temperature <= 1'h0;
    tick(4);
    #1;
    chk(high_voltage_source_enable & soft_start_active, 1'h1);
  endtask : t_therm
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    reset = 1'h1;
    {supply_start_threshold, supply_reset_level, brown_out, over_temperature} = 4'h0;
    {pwm_demand, hot, fault} = 3'h0;
    tick(4);
    reset <= 1'h0;
    t_pre();
    t_run();
    t_window(1'h0, 8);
    t_window(1'h1, 20);
    t_therm();
    give_verdict();
  end
endmodule : latchoff_thermal_fault_supervisor_test
